/* File: src/sent_tx_pkg.sv */
// Shared constants, register map, frame timing and checksum helper of the position transmitter.
package sent_tx_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and tick timing.
    localparam int          CLK_MHZ          = 100;
    localparam int          TICK_TIME_PS     = 3360000;
    localparam int          TICK_MIN_PS      = 3000000;
    localparam int          TICK_MAX_PS      = 3670000;
    localparam int          TICK_CYCLES_INT  = (TICK_TIME_PS * CLK_MHZ) / 1000000;
    localparam logic [8:0]  TICK_CYCLES      = TICK_CYCLES_INT[8:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse and frame lengths in ticks.
    localparam logic [8:0]  LOW_TICKS        = 9'h005;
    localparam logic [8:0]  NIBBLE_BASE      = 9'h00C;
    localparam logic [8:0]  SYNC_TICKS       = 9'h038;
    localparam logic [8:0]  FRAME_FIXED      = 9'h10E;
    localparam logic [8:0]  FRAME_VAR_MIN    = 9'h098;
    localparam logic [8:0]  FRAME_VAR_MAX    = 9'h104;
    localparam logic [8:0]  FRAME_FMT2_MAX   = 9'h0DC;
    localparam logic [3:0]  IDX_SYNC         = 4'h0;
    localparam logic [3:0]  IDX_STATUS       = 4'h1;
    localparam logic [3:0]  IDX_CRC          = 4'h8;
    localparam logic [3:0]  IDX_PAUSE        = 4'h9;
    localparam logic [3:0]  STATUS_NORMAL    = 4'h0;
    localparam logic [3:0]  STATUS_DIAG      = 4'h3;
    localparam logic [3:0]  CRC_SEED         = 4'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses.
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_OFFSET      = 8'h04;
    localparam logic [7:0]  ADDR_SLOPE       = 8'h08;
    localparam logic [7:0]  ADDR_STATUS      = 8'h0C;
    localparam logic [7:0]  ADDR_MASK        = 8'h10;
    localparam logic [7:0]  ADDR_FRAME       = 8'h14;

    // Control register fields.
    localparam int          CTRL_ENABLE      = 0;
    localparam int          CTRL_FORMAT2     = 1;
    localparam int          CTRL_PAUSE_REV3  = 2;
    localparam int          CTRL_CRC_REV3    = 3;
    localparam int          CTRL_FALLING     = 4;
    localparam int          CTRL_WIDTH       = 5;
    localparam logic [4:0]  CTRL_RESET       = 5'h00;
    localparam logic [11:0] OFFSET_RESET     = 12'h000;
    localparam logic [15:0] SLOPE_RESET      = 16'h0100;

    // Status and mask fields.
    localparam int          EV_FRAME_DONE    = 0;
    localparam int          EV_FAULT         = 1;
    localparam int          EV_WIDTH         = 2;
    localparam logic [1:0]  EV_RESET         = 2'h0;

    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ       = 2'h3;

    // Generator x^4+x^3+x^2+1 applied to a nibble shifted in from the left.
    function automatic logic [3:0] crc_table(input logic [3:0] c);
        logic [3:0] t;
        t = 4'h0;
        unique case (c)
            4'h0: t = 4'h0;
            4'h1: t = 4'hD;
            4'h2: t = 4'h7;
            4'h3: t = 4'hA;
            4'h4: t = 4'hE;
            4'h5: t = 4'h3;
            4'h6: t = 4'h9;
            4'h7: t = 4'h4;
            4'h8: t = 4'h1;
            4'h9: t = 4'hC;
            4'hA: t = 4'h6;
            4'hB: t = 4'hB;
            4'hC: t = 4'hF;
            4'hD: t = 4'h2;
            4'hE: t = 4'h8;
            4'hF: t = 4'h5;
        endcase
        return t;
    endfunction

    // Checksum over six data nibbles; the newer variant folds in one extra zero nibble.
    function automatic logic [3:0] sent_crc(input logic [23:0] d, input logic rev3);
        logic [3:0] c;
        c = CRC_SEED;
        for (int i = 5; i >= 0; i--) begin
            c = crc_table(c) ^ d[i*4 +: 4];
        end
        if (rev3) begin
            c = crc_table(c);
        end
        return c;
    endfunction

endpackage

/* File: src/angle_to_code.sv */
// Maps the electrical angle to a 12-bit output code by zero offset and slope.
`timescale 1ns/100ps
`default_nettype none

module angle_to_code (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [11:0] angle_i,
    input  wire logic [11:0] offset_i,
    input  wire logic [15:0] slope_i,
    input  wire logic        falling_i,
    output logic      [11:0] code_o
);

    logic [11:0] rel_angle;
    logic [27:0] scaled;
    logic [11:0] clamped;
    logic [11:0] next_code;

    // The zero offset rotates the angle, the slope is an unsigned gain with eight fraction bits.
    assign rel_angle = angle_i - offset_i;
    assign scaled    = {16'h0000, rel_angle} * {12'h000, slope_i};
    assign clamped   = (scaled[27:20] != 8'h00) ? 12'hFFF : scaled[19:8];
    assign next_code = falling_i ? ~clamped : clamped;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            code_o <= 12'h000;
        end else begin
            code_o <= next_code;
        end
    end

endmodule
`default_nettype wire

/* File: src/sent_position_transmitter.sv */
// Single-edge nibble frame transmitter with its register slave and event interrupt.
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Zero nibble: 5 low, 7 high ticks
// - Nibble lasts 12 plus value ticks
// - Value fifteen lasts 27 ticks
// - Sync: 5 low, 51 high ticks
// - Sync, status, six data, checksum
// - Pause pads frame to 270 ticks
// - Status 0000 normal, 0011 on fault
// - Format one: position, counter, inverted nibble
// - Format one lengths 152-260 or 270
// - Format two: position, zeros, under 220
// - Revision two framing, revision three selectable
// - Position code 0 to 4095
// - Zero offset and rising/falling slope
// - Pause only with revision three behaviour
module sent_position_transmitter (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic [11:0] angle_i,
    input  wire logic        fault_i,
    output logic             sent_o,
    output logic             irq_o
);
    import sent_tx_pkg::*;

    typedef enum logic [0:0] {ST_IDLE, ST_RUN} tx_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Register slave.
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [11:0]           zero_offset;
    logic [15:0]           slope;
    logic [EV_WIDTH-1:0]   ev_status;
    logic [EV_WIDTH-1:0]   ev_mask;
    logic                  wr_pending;
    logic [7:0]            wr_addr;
    logic                  access;
    logic                  rd_access;
    logic                  status_rd;
    logic [31:0]           rd_value;
    logic [EV_WIDTH-1:0]   ev_set;
    logic [EV_WIDTH-1:0]   next_status;

    assign access    = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
    assign rd_access = access && !hwrite_i;
    assign status_rd = rd_access && (haddr_i[7:0] == ADDR_STATUS);

    logic [11:0] position;
    logic [7:0]  roll_cnt;
    logic [11:0] frame_pos;

    // Unmapped addresses read as zero and ignore writes.
    assign rd_value =
        (haddr_i[7:0] == ADDR_CTRL)   ? {27'h0000000, ctrl} :
        (haddr_i[7:0] == ADDR_OFFSET) ? {20'h00000, zero_offset} :
        (haddr_i[7:0] == ADDR_SLOPE)  ? {16'h0000, slope} :
        (haddr_i[7:0] == ADDR_STATUS) ? {30'h00000000, ev_status} :
        (haddr_i[7:0] == ADDR_MASK)   ? {30'h00000000, ev_mask} :
        (haddr_i[7:0] == ADDR_FRAME)  ? {12'h000, roll_cnt, frame_pos} :
        32'h00000000;

    // A new event wins over the clear of a status read in the same cycle.
    assign next_status = (status_rd ? {EV_WIDTH{1'b0}} : ev_status) | ev_set;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_pending  <= 1'b0;
            wr_addr     <= 8'h00;
            hrdata_o    <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            wr_pending  <= access && hwrite_i;
            wr_addr     <= haddr_i[7:0];
            hrdata_o    <= rd_access ? rd_value : 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl        <= CTRL_RESET;
            zero_offset <= OFFSET_RESET;
            slope       <= SLOPE_RESET;
            ev_mask     <= EV_RESET;
        end else if (wr_pending) begin
            if (wr_addr == ADDR_CTRL) ctrl <= hwdata_i[CTRL_WIDTH-1:0];
            if (wr_addr == ADDR_OFFSET) zero_offset <= hwdata_i[11:0];
            if (wr_addr == ADDR_SLOPE) slope <= hwdata_i[15:0];
            if (wr_addr == ADDR_MASK) ev_mask <= hwdata_i[EV_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ev_status <= EV_RESET;
            irq_o     <= 1'b0;
        end else begin
            ev_status <= next_status;
            irq_o     <= |(next_status & ev_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Position mapping.
    angle_to_code u_map (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .angle_i   (angle_i),
        .offset_i  (zero_offset),
        .slope_i   (slope),
        .falling_i (ctrl[CTRL_FALLING]),
        .code_o    (position)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Tick generator; restarts with each frame so the sync pulse is whole.
    logic [8:0] tick_cnt;
    logic       tick_stb;
    logic       frame_start;

    assign tick_stb = (tick_cnt == TICK_CYCLES - 9'h001);

    always_ff @(posedge clk_i) begin
        if (reset_i || frame_start || tick_stb) begin
            tick_cnt <= 9'h000;
        end else begin
            tick_cnt <= tick_cnt + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame sequencer.
    tx_state_t   state;
    logic [3:0]  idx;
    logic [8:0]  ptick;
    logic [8:0]  plen;
    logic [8:0]  frame_ticks;
    logic        frame_fault;
    logic [7:0]  frame_cnt;
    logic        frame_fmt2;
    logic        frame_pause;
    logic        frame_crc3;
    logic        fault_q;
    logic [3:0]  nib [0:8];
    logic [23:0] data_word;
    logic        pulse_end;
    logic        frame_end;
    logic        restart;
    logic [3:0]  next_idx;
    logic [8:0]  next_plen;

    assign data_word = frame_fmt2 ? {frame_pos, 12'h000} :
                       {frame_pos, frame_cnt, ~frame_pos[11:8]};
    assign nib[0]    = 4'h0;
    assign nib[1]    = frame_fault ? STATUS_DIAG : STATUS_NORMAL;
    assign nib[8]    = sent_crc(data_word, frame_crc3);

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_data
            assign nib[g + 2] = data_word[(5 - g) * 4 +: 4];
        end
    endgenerate

    assign pulse_end   = (state == ST_RUN) && tick_stb && (ptick == plen - 9'h001);
    assign frame_end   = pulse_end && (idx == IDX_PAUSE || (idx == IDX_CRC && !frame_pause));
    assign restart     = (state == ST_IDLE || frame_end) && ctrl[CTRL_ENABLE];
    assign frame_start = restart;
    assign next_idx    = (idx == IDX_CRC) ? IDX_PAUSE : idx + 4'h1;
    // Nibble length grows with the value; the pause fills the rest of the fixed frame.
    assign next_plen   = (next_idx == IDX_PAUSE) ? FRAME_FIXED - frame_ticks - 9'h001 :
                         NIBBLE_BASE + {5'h00, nib[next_idx]};
    assign ev_set      = {fault_i && !fault_q, frame_end};

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state       <= ST_IDLE;
            idx         <= IDX_SYNC;
            ptick       <= 9'h000;
            plen        <= SYNC_TICKS;
            frame_ticks <= 9'h000;
        end else if (restart) begin
            state       <= ST_RUN;
            idx         <= IDX_SYNC;
            ptick       <= 9'h000;
            plen        <= SYNC_TICKS;
            frame_ticks <= 9'h000;
        end else if (frame_end) begin
            state       <= ST_IDLE;
        end else if (state == ST_RUN && tick_stb) begin
            frame_ticks <= frame_ticks + 9'h001;
            ptick       <= pulse_end ? 9'h000 : ptick + 9'h001;
            if (pulse_end) begin
                idx  <= next_idx;
                plen <= next_plen;
            end
        end
    end

    // Frame contents are frozen at the start so the checksum matches what is sent.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            frame_pos   <= 12'h000;
            frame_fault <= 1'b0;
            frame_cnt   <= 8'h00;
            roll_cnt    <= 8'h00;
            frame_fmt2  <= 1'b0;
            frame_pause <= 1'b0;
            frame_crc3  <= 1'b0;
            fault_q     <= 1'b0;
        end else begin
            fault_q <= fault_i;
            if (restart) begin
                frame_pos   <= position;
                frame_fault <= fault_i;
                frame_cnt   <= roll_cnt;
                roll_cnt    <= roll_cnt + 8'h01;
                frame_fmt2  <= ctrl[CTRL_FORMAT2];
                frame_pause <= ctrl[CTRL_PAUSE_REV3];
                frame_crc3  <= ctrl[CTRL_CRC_REV3];
            end
        end
    end

    // Every pulse opens on a falling edge for the receiver to time from.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sent_o <= 1'b1;
        end else begin
            sent_o <= !(state == ST_RUN && !frame_end && ptick < LOW_TICKS);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [10:0] low_run;
    logic [15:0] gap_run;
    logic [8:0]  gap_len;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            low_run <= 11'h000;
            gap_run <= 16'h0000;
            gap_len <= 9'h000;
        end else begin
            low_run <= sent_o ? 11'h000 : low_run + 11'h001;
            gap_run <= (sent_o && !$past(sent_o)) ? gap_run + 16'h0001 :
                       ($fell(sent_o) ? 16'h0001 : gap_run + 16'h0001);
            if ($fell(sent_o)) gap_len <= plen;
        end
    end

    a_low_width: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(sent_o) |-> (low_run == 11'(LOW_TICKS) * 11'(TICK_CYCLES)))
        else $error("low phase is not five ticks");
    a_pulse_len: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(sent_o) && $past(gap_len) != 9'h000 && $past(state) == ST_RUN && idx != IDX_SYNC
        |-> (gap_run == 16'(gap_len) * 16'(TICK_CYCLES)))
        else $error("pulse length does not match its value");
    a_nibble_max: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == ST_RUN && idx >= IDX_STATUS && idx <= IDX_CRC) |-> (plen <= 9'h01B))
        else $error("nibble longer than 27 ticks");
    a_sync_len: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == ST_RUN && idx == IDX_SYNC) |-> (plen == 9'h038))
        else $error("sync pulse is not 56 ticks");
    a_status_bits: assert property (@(posedge clk_i) disable iff (reset_i)
        (nib[1] == 4'h0 || nib[1] == 4'h3) && (nib[1] == 4'h3) == frame_fault)
        else $error("status nibble wrong");
    a_pause_frame: assert property (@(posedge clk_i) disable iff (reset_i)
        (frame_end && frame_pause) |-> (frame_ticks == 9'h10D))
        else $error("paused frame is not 270 ticks");
    a_var_frame: assert property (@(posedge clk_i) disable iff (reset_i)
        (frame_end && !frame_pause && !frame_fmt2)
        |-> (frame_ticks >= 9'h097 && frame_ticks <= 9'h103))
        else $error("format one frame out of range");
    a_fmt2_frame: assert property (@(posedge clk_i) disable iff (reset_i)
        (frame_end && !frame_pause && frame_fmt2) |-> (frame_ticks < 9'h0DB))
        else $error("format two frame too long");
    a_roll_step: assert property (@(posedge clk_i) disable iff (reset_i)
        restart |=> (roll_cnt == $past(roll_cnt) + 8'h01) && (frame_cnt == $past(roll_cnt)))
        else $error("rolling counter did not step");
    a_inv_nibble: assert property (@(posedge clk_i) disable iff (reset_i)
        !frame_fmt2 |-> (nib[7] == ~nib[2]))
        else $error("inverted copy wrong");

    c_pause_frame: cover property (@(posedge clk_i) disable iff (reset_i)
        frame_end && frame_pause);
    c_fault_frame: cover property (@(posedge clk_i) disable iff (reset_i)
        frame_end && frame_fault);
    c_fmt2_frame: cover property (@(posedge clk_i) disable iff (reset_i)
        frame_end && frame_fmt2 && frame_crc3);

endmodule
`default_nettype wire

/* File: test/sent_rx_model.sv */
// Frame receiver that stands on the line of the position transmitter.
`timescale 1ns/100ps
`default_nettype none

module sent_rx_model (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        line_i,
    output logic             frame_done_o,
    output logic      [31:0] nibbles_o,
    output logic      [8:0]  frame_ticks_o,
    output logic      [31:0] tick_cycles_o,
    output logic             shape_err_o
);
    logic        prev;
    logic [31:0] cnt;
    logic [31:0] low;
    logic [31:0] total;
    logic [3:0]  idx;
    logic [31:0] tick_safe;
    logic [31:0] ticks;
    logic [31:0] val;
    logic [31:0] ftot;

    assign tick_safe = (tick_cycles_o == 32'h0) ? 32'h1 : tick_cycles_o;
    assign ticks     = cnt / tick_safe;
    assign val       = ticks - 32'hC;
    assign ftot      = (total + cnt) / tick_safe;

    ////////////////////////////////////////////////////////////////////////////////
    // Each period runs from one falling edge to the next; the sync period sets the tick.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prev          <= 1'b1;
            cnt           <= 32'h0;
            low           <= 32'h0;
            total         <= 32'h0;
            idx           <= 4'h0;
            frame_done_o  <= 1'b0;
            nibbles_o     <= 32'h0;
            frame_ticks_o <= 9'h000;
            tick_cycles_o <= 32'h0;
            shape_err_o   <= 1'b0;
        end else begin
            prev         <= line_i;
            frame_done_o <= 1'b0;
            cnt          <= cnt + 32'h1;
            low          <= line_i ? low : low + 32'h1;
            if (prev && !line_i) begin
                cnt <= 32'h1;
                low <= 32'h1;
                if (idx == 4'h1) begin
                    tick_cycles_o <= cnt / 32'h38;
                    total         <= cnt;
                    idx           <= 4'h2;
                    if ((low * 32'h38 != cnt * 32'h5) || (cnt % 32'h38 != 32'h0)) begin
                        shape_err_o <= 1'b1;
                    end
                end else if (idx >= 4'h2) begin
                    nibbles_o <= {nibbles_o[27:0], val[3:0]};
                    total     <= total + cnt;
                    if ((low != tick_safe * 32'h5) || (ticks * tick_safe != cnt) ||
                        (ticks < 32'hC) || (ticks > 32'h1B)) begin
                        shape_err_o <= 1'b1;
                    end
                    if (idx == 4'h9) begin
                        idx           <= 4'h1;
                        frame_done_o  <= 1'b1;
                        frame_ticks_o <= ftot[8:0];
                    end else begin
                        idx <= idx + 4'h1;
                    end
                end else begin
                    idx <= 4'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire

/* File: test/sent_position_transmitter_test.sv */
// Self-checking bench of the position transmitter with a frame receiver on its line.
`timescale 1ns/100ps
`default_nettype none

module sent_position_transmitter_test;
    import sent_tx_pkg::*;

    logic        clk_i    = 1'b0;
    logic        reset_i  = 1'b1;
    logic        hsel_i   = 1'b0;
    logic [31:0] haddr_i  = 32'h0;
    logic [1:0]  htrans_i = 2'h0;
    logic        hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [11:0] angle_i  = 12'h000;
    logic        fault_i  = 1'b0;
    logic [31:0] seed     = 32'h6FBC;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        hresp_o;
    logic        sent_o;
    logic        irq_o;
    logic        done;
    logic [31:0] nib;
    logic [8:0]  fticks;
    logic [31:0] tick;
    logic        serr;
    logic [31:0] rd;
    logic [11:0] off;
    logic [11:0] pos;
    logic [31:0] expn;
    int          n;
    int          fails    = 0;
    int          n_checks = 0;

    sent_position_transmitter dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .angle_i(angle_i), .fault_i(fault_i), .sent_o(sent_o),
        .irq_o(irq_o)
    );

    sent_rx_model rx_u (
        .clk_i(clk_i), .reset_i(reset_i), .line_i(sent_o), .frame_done_o(done),
        .nibbles_o(nib), .frame_ticks_o(fticks), .tick_cycles_o(tick), .shape_err_o(serr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [3:0] crc_step(input logic [3:0] c);
        logic [7:0] v;
        v = {c, 4'h0};
        for (int i = 7; i >= 4; i--) begin
            if (v[i]) begin
                v = v ^ (8'h1D << (i - 4));
            end
        end
        return v[3:0];
    endfunction

    function automatic logic [11:0] exp_pos(input logic [11:0] a, input logic [11:0] o);
        logic [27:0] p;
        p = ({16'h0000, a - o} * 28'h0000180) >> 8;
        if (p > 28'h0000FFF) begin
            p = 28'h0000FFF;
        end
        return ~p[11:0];
    endfunction

    function automatic logic [31:0] exp_frame(input logic [11:0] p);
        logic [23:0] d;
        logic [3:0]  c;
        d = {p, 8'h00, ~p[11:8]};
        c = CRC_SEED;
        for (int i = 5; i >= 0; i--) begin
            c = crc_step(c) ^ d[i*4 +: 4];
        end
        return {STATUS_DIAG, d, crc_step(c)};
    endfunction

    function automatic logic [8:0] exp_ticks(input logic [31:0] v);
        logic [8:0] t;
        t = SYNC_TICKS;
        for (int k = 0; k < 8; k++) begin
            t = t + NIBBLE_BASE + {5'h00, v[k*4 +: 4]};
        end
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready(output logic [31:0] r);
        logic rdy;
        int   k;
        rdy = 1'b0;
        k = 0;
        while (rdy !== 1'b1) begin
            @(negedge clk_i);
            rdy = hreadyout_o;
            r = hrdata_o;
            @(posedge clk_i);
            k++;
            if (k > 16 && rdy !== 1'b1) begin
                fails++;
                conclude();
            end
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel_i   <= 1'b1;
        haddr_i  <= {24'h000000, a};
        htrans_i <= HTRANS_NONSEQ;
        hwrite_i <= w;
        wait_ready(r);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_ready(r);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        chk(rd, e);
    endtask

    task automatic probe(input logic e);
        @(negedge clk_i);
        chk({30'h0, hresp_o, irq_o}, {31'h0, e});
        @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        chk({30'h0, sent_o, irq_o}, 32'h2);
        @(posedge clk_i);
        for (int k = 0; k < 7; k++) begin
            rdchk(8'(k * 4), (k == 2) ? {16'h0000, SLOPE_RESET} : 32'h0);
        end
        repeat (16) seed = lfsr(seed);
        off = seed[11:0];
        repeat (16) seed = lfsr(seed);
        angle_i <= seed[11:0];
        bus(1'b1, ADDR_OFFSET, {20'hFFFFF, off}, rd);
        bus(1'b1, ADDR_SLOPE, 32'h0000_0180, rd);
        bus(1'b1, 8'h18, 32'hFFFF_FFFF, rd);
        rdchk(ADDR_OFFSET, {20'h00000, off});
        rdchk(ADDR_SLOPE, 32'h0000_0180);
        rdchk(8'h18, 32'h0);
        fault_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        probe(1'b0);
        bus(1'b1, ADDR_MASK, 32'h3, rd);
        repeat (2) @(posedge clk_i);
        probe(1'b1);
        rdchk(ADDR_STATUS, 32'h2);
        repeat (2) @(posedge clk_i);
        probe(1'b0);
        rdchk(ADDR_STATUS, 32'h0);
        pos = exp_pos(angle_i, off);
        // The mapped code lags the control word by one cycle, so set the falling direction before enabling.
        bus(1'b1, ADDR_CTRL, 32'h0000_0018, rd);
        bus(1'b1, ADDR_CTRL, 32'h0000_0019, rd);
        rdchk(ADDR_CTRL, 32'h0000_0019);
        rdchk(ADDR_FRAME, {12'h000, 8'h01, pos});
        n = 0;
        while (done !== 1'b1) begin
            @(negedge clk_i);
            n++;
            if (n > 95000) begin
                fails++;
                conclude();
            end
        end
        expn = exp_frame(pos);
        chk(nib, expn);
        chk({23'h0, fticks}, {23'h0, exp_ticks(expn)});
        chk({31'h0, fticks >= FRAME_VAR_MIN && fticks <= FRAME_VAR_MAX}, 32'h1);
        chk({31'h0, serr}, 32'h0);
        chk(tick, 32'h150);
        @(posedge clk_i);
        probe(1'b1);
        rdchk(ADDR_STATUS, 32'h1);
        rdchk(ADDR_FRAME, {12'h000, 8'h02, pos});
        conclude();
    end
endmodule

`default_nettype wire
